// ===== usbpcr_defs.vh
/*
 * Constants for the PHY common block control register: offset, bit
 * positions, writable mask and reset value.
 * Assumes a 12-bit byte address within the PHY register space.
 */
`ifndef USBPCR_DEFS_VH
`define USBPCR_DEFS_VH

// ----------------------------------------------------------------
// Address map
// ----------------------------------------------------------------
`define USBPCR_ADDR_W        12
`define USBPCR_OFS_COMMON    12'h000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define USBPCR_B_CLK_OFF     31
`define USBPCR_B_TEST_SEL    24
`define USBPCR_B_XTAL_AMP    23
`define USBPCR_B_REF_RATE    19
`define USBPCR_B_CORE_RDY    18
`define USBPCR_B_FAST_PLL    17
`define USBPCR_B_HS_PLL      16
`define USBPCR_B_COM_SUSP_N  15
`define USBPCR_B_XTAL_SUSP_N 14
`define USBPCR_B_COM_CLK_OK  12
`define USBPCR_B_SS_PLL      11
`define USBPCR_B_SS_CLK_OK   10
`define USBPCR_B_TIMER_OFF   9
`define USBPCR_B_GATE_BYP    0

// ----------------------------------------------------------------
// Masks and reset value
// ----------------------------------------------------------------
`define USBPCR_WR_MASK       32'h818B_CA01
`define USBPCR_RO_MASK       32'h0004_1400
`define USBPCR_RESET_VAL     32'h0001_0000
`define USBPCR_AFE_CNT       2

`endif

// ===== usbpcr_lpm_dflt.v
/*
 * Default source for the fast PLL startup bit: picks the speed-mode
 * field of the configuration image and holds the last loaded value.
 * Assumes image_load pulses for one cycle when the image is valid.
 */
`include "usbpcr_defs.vh"

module usbpcr_lpm_dflt (
  input  wire clk_sys,
  input  wire reset,
  input  wire image_load,
  input  wire hs_mode,
  input  wire eeprom_present,
  input  wire eeprom_lpm_hs,
  input  wire eeprom_lpm_fs,
  input  wire otp_present,
  input  wire otp_lpm_hs,
  input  wire otp_lpm_fs,
  output reg  image_lpm_r,
  output reg  image_lpm_nxt
);

  // ----------------------------------------------------------------
  // Source priority: EEPROM, then OTP, then zero
  // ----------------------------------------------------------------
  always @*
  begin
    image_lpm_nxt = image_lpm_r;
    if (image_load)
    begin
      if (eeprom_present)
        image_lpm_nxt = hs_mode ? eeprom_lpm_hs : eeprom_lpm_fs;
      else if (otp_present)
        image_lpm_nxt = hs_mode ? otp_lpm_hs : otp_lpm_fs;
      else
        image_lpm_nxt = 1'b0;
    end
  end

  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      image_lpm_r <= 1'b0;
    else
      image_lpm_r <= image_lpm_nxt;
  end

endmodule // usbpcr_lpm_dflt

// ===== usbpcr_top.v
/*
 * PHY common block control and status register with its analog
 * control outputs and readiness flags.
 * Assumes a single-cycle strobe register port synchronous to clk_sys,
 * and status inputs already synchronous to clk_sys.
 */
// Added by the designer: the address-and-strobe port.
`include "usbpcr_defs.vh"

module usbpcr_top (
  input  wire                     clk_sys,
  input  wire                     reset,
  input  wire [`USBPCR_ADDR_W-1:0] reg_addr,
  input  wire [31:0]              reg_wdata,
  input  wire                     reg_wr,
  input  wire                     reg_rd,
  output reg  [31:0]              reg_rdata,
  input  wire                     usb_reset,
  input  wire                     lite_reset,
  input  wire                     image_load,
  input  wire                     hs_mode,
  input  wire                     eeprom_present,
  input  wire                     eeprom_lpm_hs,
  input  wire                     eeprom_lpm_fs,
  input  wire                     otp_present,
  input  wire                     otp_lpm_hs,
  input  wire                     otp_lpm_fs,
  input  wire                     core_por_in,
  input  wire                     hv_por_in,
  input  wire                     common_pll_usable_in,
  input  wire                     ss_pll_usable_in,
  input  wire                     global_suspend_n,
  input  wire [1:0]               afe_local_suspend_n,
  output reg                      common_reg_clk_off,
  output reg                      common_test_path_select,
  output reg                      crystal_amplitude_select,
  output reg                      pll_reference_rate_select,
  output reg                      pll_fast_startup_enable,
  output reg                      hs_pll_enable,
  output reg                      common_suspend_n,
  output reg                      crystal_suspend_n,
  output reg                      common_bias_pd,
  output reg                      crystal_osc_pd,
  output reg                      crystal_clk_run,
  output reg  [1:0]               afe_suspend_n,
  output reg                      ss_tx_pll_enable,
  output reg                      frontend_ready_timer_off,
  output reg                      clock_gating_bypass
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg  [31:0] ctrl_r;
  reg  [31:0] ctrl_nxt;
  reg         core_rdy_r;
  reg         com_clk_ok_r;
  reg         ss_clk_ok_r;
  reg  [31:0] rdata_nxt;
  wire        image_lpm;
  wire        sel_common;
  wire        wr_hit;
  wire        rd_hit;
  wire        regs_gated;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function addr_hit;
    input [`USBPCR_ADDR_W-1:0] a;
    begin
      addr_hit = (a == `USBPCR_OFS_COMMON);
    end
  endfunction

  function [31:0] status_view;
    input [31:0] ctl;
    input        core_rdy;
    input        com_ok;
    input        ss_ok;
    reg   [31:0] v;
    begin
      v = ctl & `USBPCR_WR_MASK;
      v[`USBPCR_B_CORE_RDY]  = core_rdy;
      v[`USBPCR_B_COM_CLK_OK] = com_ok;
      v[`USBPCR_B_SS_CLK_OK] = ss_ok;
      status_view = v;
    end
  endfunction

  assign sel_common = addr_hit(reg_addr);
  assign wr_hit     = reg_wr & sel_common;
  assign rd_hit     = reg_rd & sel_common;
  assign regs_gated = ctrl_r[`USBPCR_B_CLK_OFF];

  // ----------------------------------------------------------------
  // Configuration image default
  // ----------------------------------------------------------------
  usbpcr_lpm_dflt u_lpm_dflt (
    .clk_sys        (clk_sys),
    .reset          (reset),
    .image_load     (image_load),
    .hs_mode        (hs_mode),
    .eeprom_present (eeprom_present),
    .eeprom_lpm_hs  (eeprom_lpm_hs),
    .eeprom_lpm_fs  (eeprom_lpm_fs),
    .otp_present    (otp_present),
    .otp_lpm_hs     (otp_lpm_hs),
    .otp_lpm_fs     (otp_lpm_fs),
    .image_lpm_r    (),
    .image_lpm_nxt  (image_lpm)
  );

  // ----------------------------------------------------------------
  // Control register next value
  // ----------------------------------------------------------------
  always @*
  begin
    ctrl_nxt = ctrl_r;
    if (wr_hit)
    begin
      if (regs_gated)
      begin
        // Only the gate bit itself stays writable while gated
        ctrl_nxt[`USBPCR_B_CLK_OFF] = reg_wdata[`USBPCR_B_CLK_OFF];
      end
      else
      begin
        ctrl_nxt = reg_wdata & `USBPCR_WR_MASK;
      end
    end
    if (image_load || usb_reset || lite_reset)
      ctrl_nxt[`USBPCR_B_FAST_PLL] = image_lpm;
  end

  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      ctrl_r <= `USBPCR_RESET_VAL;
    else
      ctrl_r <= ctrl_nxt;
  end

  // ----------------------------------------------------------------
  // Status flags, frozen while the register clocks are gated
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      core_rdy_r   <= 1'b0;
      com_clk_ok_r <= 1'b0;
      ss_clk_ok_r  <= 1'b0;
    end
    else if (!regs_gated)
    begin
      core_rdy_r   <= core_por_in & hv_por_in;
      com_clk_ok_r <= common_pll_usable_in;
      ss_clk_ok_r  <= ss_pll_usable_in;
    end
  end

  // ----------------------------------------------------------------
  // Read port: data valid only in the cycle after the strobe
  // ----------------------------------------------------------------
  always @*
  begin
    rdata_nxt = 32'h0000_0000;
    if (rd_hit)
      rdata_nxt = status_view(ctrl_r, core_rdy_r, com_clk_ok_r, ss_clk_ok_r);
  end

  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      reg_rdata <= 32'h0000_0000;
    else
      reg_rdata <= rdata_nxt;
  end

  // ----------------------------------------------------------------
  // Analog control outputs
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      common_reg_clk_off        <= 1'b0;
      common_test_path_select   <= 1'b0;
      crystal_amplitude_select  <= 1'b0;
      pll_reference_rate_select <= 1'b0;
      pll_fast_startup_enable   <= 1'b0;
      hs_pll_enable             <= 1'b1;
      ss_tx_pll_enable          <= 1'b0;
      frontend_ready_timer_off  <= 1'b0;
      clock_gating_bypass       <= 1'b0;
    end
    else
    begin
      common_reg_clk_off        <= ctrl_nxt[`USBPCR_B_CLK_OFF];
      common_test_path_select   <= ctrl_nxt[`USBPCR_B_TEST_SEL];
      crystal_amplitude_select  <= ctrl_nxt[`USBPCR_B_XTAL_AMP];
      pll_reference_rate_select <= ctrl_nxt[`USBPCR_B_REF_RATE];
      pll_fast_startup_enable   <= ctrl_nxt[`USBPCR_B_FAST_PLL];
      hs_pll_enable             <= ctrl_nxt[`USBPCR_B_HS_PLL];
      ss_tx_pll_enable          <= ctrl_nxt[`USBPCR_B_SS_PLL];
      frontend_ready_timer_off  <= ctrl_nxt[`USBPCR_B_TIMER_OFF];
      clock_gating_bypass       <= ctrl_nxt[`USBPCR_B_GATE_BYP];
    end
  end

  // ----------------------------------------------------------------
  // Suspend and power-down control
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      common_suspend_n  <= 1'b0;
      crystal_suspend_n <= 1'b0;
      common_bias_pd    <= 1'b1;
      crystal_osc_pd    <= 1'b1;
      crystal_clk_run   <= 1'b0;
      afe_suspend_n     <= 2'b00;
    end
    else
    begin
      common_suspend_n  <= ctrl_nxt[`USBPCR_B_COM_SUSP_N];
      crystal_suspend_n <= ctrl_nxt[`USBPCR_B_XTAL_SUSP_N];
      common_bias_pd    <= ~ctrl_nxt[`USBPCR_B_COM_SUSP_N];
      crystal_osc_pd    <= ~ctrl_nxt[`USBPCR_B_XTAL_SUSP_N];
      // Global suspend does not stop the crystal clock
      crystal_clk_run   <= ctrl_nxt[`USBPCR_B_XTAL_SUSP_N];
      if (!ctrl_nxt[`USBPCR_B_COM_SUSP_N])
        afe_suspend_n   <= 2'b00;
      else
        afe_suspend_n   <= afe_local_suspend_n & {2{global_suspend_n}};
    end
  end

endmodule // usbpcr_top

// ===== usbpcr_properties.sv
/*
 * Assertions on the common block control register and its outputs.
 * Assumes it is bound to usbpcr_top and sees only that module's ports.
 */
`include "usbpcr_defs.vh"

module usbpcr_chk (
  input wire                      clk_sys,
  input wire                      reset,
  input wire [`USBPCR_ADDR_W-1:0] reg_addr,
  input wire [31:0]               reg_wdata,
  input wire                      reg_wr,
  input wire                      reg_rd,
  input wire [31:0]               reg_rdata,
  input wire                      hv_por_in,
  input wire                      common_reg_clk_off,
  input wire                      hs_pll_enable,
  input wire                      common_suspend_n,
  input wire                      crystal_suspend_n,
  input wire                      common_bias_pd,
  input wire                      crystal_osc_pd,
  input wire                      crystal_clk_run,
  input wire [1:0]                afe_suspend_n,
  input wire                      frontend_ready_timer_off,
  input wire                      clock_gating_bypass
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  AST_RSVD_ZERO: assert property (
    $past(reg_rd) |-> (reg_rdata & 32'h7E70_21FE) == 32'h0000_0000) else $error("reserved set");
  AST_SUSP_ALL: assert property (
    !common_suspend_n |-> afe_suspend_n == 2'b00 && common_bias_pd) else $error("afe awake");
  AST_XTAL_PD: assert property (
    crystal_osc_pd != crystal_suspend_n) else $error("crystal power wrong");
  AST_XTAL_RUN: assert property (
    crystal_suspend_n |-> crystal_clk_run) else $error("crystal clock stopped");
  AST_CORE_RDY: assert property (
    $past(reg_rd) && !$past(hv_por_in) && !$past(hv_por_in, 2) && !$past(hv_por_in, 3)
    && !$past(common_reg_clk_off) && !$past(common_reg_clk_off, 2) |-> !reg_rdata[18])
    else $error("core ready not gated");
  AST_RST_VAL: assert property (
    $fell(reset) |-> hs_pll_enable && !common_suspend_n && !clock_gating_bypass)
    else $error("reset values wrong");
  AST_BYPASS: assert property (
    reg_wr && reg_addr == 12'h000 && !common_reg_clk_off
    |=> clock_gating_bypass == $past(reg_wdata[0])) else $error("bypass not written");
  AST_TIMER: assert property (
    reg_wr && reg_addr == 12'h000 && !common_reg_clk_off
    |=> frontend_ready_timer_off == $past(reg_wdata[9])) else $error("timer bit not written");
  AST_CLK_OFF: assert property (
    reg_wr && reg_addr == 12'h000 |=> common_reg_clk_off == $past(reg_wdata[31]))
    else $error("clock off not written");
endmodule // usbpcr_chk

bind usbpcr_top usbpcr_chk chk_u (.*);

// ===== usbpcr_top_tb.sv
/*
 * Self-checking bench for the common block control register.
 * Assumes usbpcr_top and the bound checker; drives all inputs itself.
 */
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

module usbpcr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Signals and bus tasks
  // ------------------------------------------------------------
  logic        clk_sys = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, r, ctl = 32'h0001_0000, st = 32'h0, exp_v;
  logic        usb_reset = 0, lite_reset = 0, image_load = 0, hs_mode = 0, e, rd_seen = 0;
  logic        eeprom_present = 0, eeprom_lpm_hs = 0, eeprom_lpm_fs = 0;
  logic        otp_present = 0, otp_lpm_hs = 0, otp_lpm_fs = 0, global_suspend_n = 1;
  logic        core_por_in = 0, hv_por_in = 0, common_pll_usable_in = 0, ss_pll_usable_in = 0;
  logic [1:0]  afe_local_suspend_n = 2'b11, afe_suspend_n;
  logic        common_reg_clk_off, common_test_path_select, crystal_amplitude_select;
  logic        pll_reference_rate_select, pll_fast_startup_enable, hs_pll_enable;
  logic        common_suspend_n, crystal_suspend_n, common_bias_pd, crystal_osc_pd;
  logic        crystal_clk_run, ss_tx_pll_enable, frontend_ready_timer_off, clock_gating_bypass;
  logic [31:0] expq[$];
  int          err_count = 0, n_tests = 0, cyc = 0;

  usbpcr_top dut_u (.*);

  always #4 clk_sys = ~clk_sys;

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    expq.push_back(x);
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic pulse(input int k);
    @(posedge clk_sys);
    {image_load, usb_reset, lite_reset} <= 3'b001 << k;
    @(posedge clk_sys);
    {image_load, usb_reset, lite_reset} <= 3'b000;
    @(negedge clk_sys);
  endtask

  task automatic set_st(input logic [3:0] v, input logic [31:0] s);
    @(posedge clk_sys);
    {core_por_in, hv_por_in, common_pll_usable_in, ss_pll_usable_in} <= v;
    repeat (3) @(posedge clk_sys);
    st = s;
    rd(12'h000, ctl & 32'h818B_CA01 | st);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Read checker and watchdog
  // ------------------------------------------------------------
  always @(posedge clk_sys) rd_seen <= reg_rd;
  always @(negedge clk_sys)
    if (rd_seen)
    begin
      exp_v = expq.pop_front();
      `CHK(reg_rdata, exp_v)
    end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      give_verdict();
    end
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h75ab_eeba));
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    rd(12'h000, 32'h0001_0000);
    `CHK({hs_pll_enable, common_bias_pd, crystal_osc_pd}, 3'b111)
    $display("reset values done");
    for (int i = 0; i < 20; i++)
    begin
      r = $urandom & 32'h7FF7_FFFF;
      @(posedge clk_sys);
      {global_suspend_n, afe_local_suspend_n} <= r[30:28];
      wr(12'h000, r);
      ctl = r;
      rd(12'h000, ctl & 32'h818B_CA01 | st);
      `CHK({common_test_path_select, crystal_amplitude_select}, r[24:23])
      `CHK({ss_tx_pll_enable, clock_gating_bypass}, {r[11], r[0]})
      `CHK({pll_fast_startup_enable, hs_pll_enable}, r[17:16])
      `CHK({crystal_clk_run, frontend_ready_timer_off}, {r[14], r[9]})
      `CHK(afe_suspend_n, r[15] ? r[29:28] & {2{r[30]}} : 2'b00)
      `CHK({common_suspend_n, crystal_suspend_n, common_bias_pd, crystal_osc_pd}, {r[15], r[14], ~r[15], ~r[14]})
      `CHK({pll_reference_rate_select, common_reg_clk_off}, 2'b00)
    end
    wr(12'h000, 32'h0008_0000);
    `CHK(pll_reference_rate_select, 1'b1)
    ctl = 32'h0001_0000;
    wr(12'h000, ctl);
    $display("control fields done");
    set_st(4'hF, 32'h0004_1400);
    set_st(4'hB, 32'h0000_1400);
    set_st(4'hE, 32'h0004_1000);
    set_st(4'h4, 32'h0000_0000);
    $display("status flags done");
    for (int i = 0; i < 16; i++)
    begin
      r = $urandom;
      r[6:4] = i[2:0];
      @(posedge clk_sys);
      {eeprom_present, otp_present, hs_mode, eeprom_lpm_hs, eeprom_lpm_fs, otp_lpm_hs,
       otp_lpm_fs} <= r[6:0];
      e = r[6] ? (r[4] ? r[3] : r[2]) : (r[5] && (r[4] ? r[1] : r[0]));
      pulse(2);
      `CHK(pll_fast_startup_enable, e)
      wr(12'h000, {14'h0, !e, 17'h1_0000});
      rd(12'h000, {14'h0, !e, 17'h1_0000});
      @(posedge clk_sys);
      {eeprom_present, otp_present, hs_mode, eeprom_lpm_hs} <= ~r[6:3];
      pulse(i % 2);
      `CHK(pll_fast_startup_enable, e)
      ctl = {14'h0, e, 17'h1_0000};
    end
    $display("fast startup default done");
    rd(12'h004, 32'h0000_0000);
    wr(12'h000, 32'h8000_0001);
    `CHK(common_reg_clk_off, 1'b1)
    wr(12'h000, 32'h0000_0200);
    rd(12'h000, 32'h0000_0001);
    @(posedge clk_sys);
    reset <= 1'b1;
    @(posedge clk_sys);
    reset <= 1'b0;
    rd(12'h000, 32'h0001_0000);
    $display("clock off and second reset done");
    give_verdict();
  end
endmodule // usbpcr_top_tb
